// >>> tws_pkg.sv
package tws_pkg;

  // ----------------------------------------
  // Register indices, byte address = index * 4
  // ----------------------------------------
  localparam logic [7:0]  CTRL_IDX  = 8'hE8;
  localparam logic [7:0]  OWN_IDX   = 8'h9B;
  localparam logic [7:0]  DATA_IDX  = 8'h9A;
  localparam logic [7:0]  CFG_IDX   = 8'hC0;
  localparam logic [11:0] CTRL_ADDR = 12'({CTRL_IDX, 2'b00});
  localparam logic [11:0] OWN_ADDR  = 12'({OWN_IDX, 2'b00});
  localparam logic [11:0] DATA_ADDR = 12'({DATA_IDX, 2'b00});
  localparam logic [11:0] CFG_ADDR  = 12'({CFG_IDX, 2'b00});

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTRL_SDO  = 7;
  localparam int CTRL_SDE  = 6;
  localparam int CTRL_SCO  = 5;
  localparam int CTRL_SDI  = 4;
  localparam int CTRL_MSEL = 3;
  localparam int CTRL_IRST = 2;
  localparam int CTRL_DIR  = 1;
  localparam int CTRL_FLAG = 0;
  localparam int CTRL_SW_LO = 2;

  // ----------------------------------------
  // Config register fields
  // ----------------------------------------
  localparam int CFG_IE   = 0;
  localparam int CFG_GIE  = 1;
  localparam int CFG_SSEL = 2;

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] OWN_RST   = 8'h55;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [2:0] CFG_RST   = 3'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST   = 4'h7;

  typedef enum logic [2:0] {SL_IDLE, SL_RX, SL_ACKO, SL_TX, SL_ACKI} tws_slv_e;
  typedef enum logic [2:0] {RS_NONE, RS_CTRL, RS_OWN, RS_DATA, RS_CFG} tws_rsel_e;

  typedef struct packed {
    logic sclS;
    logic sdaS;
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
  } tws_bus_s;

  typedef struct packed {
    logic sdaOut;
    logic sdaOe;
    logic sclOut;
    logic sclOe;
  } tws_pins_s;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } tws_sync_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } tws_lvl_s;

endpackage : tws_pkg

// >>> tws_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tws_sync (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [1:0] din,
  output logic      [1:0] dout
);
  tws_pkg::tws_sync_s st_q;
  tws_pkg::tws_sync_s st_d;

  // ----------------------------------------
  // Two flop pin synchroniser
  // ----------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.meta = din;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{meta: 2'h3, sync: 2'h3};
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.sync;
endmodule : tws_sync
`default_nettype wire

// >>> tws_edge.sv
`timescale 1ns/1ps
`default_nettype none
module tws_edge (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         sclSync,
  input  wire logic         sdaSync,
  output tws_pkg::tws_bus_s ev
);
  tws_pkg::tws_lvl_s st_q;
  tws_pkg::tws_lvl_s st_d;

  // ----------------------------------------
  // Edge and bus condition detect
  // ----------------------------------------
  always_comb begin
    st_d       = '{scl: sclSync, sda: sdaSync};
    ev.sclS    = sclSync;
    ev.sdaS    = sdaSync;
    ev.sclRise = sclSync & ~st_q.scl;
    ev.sclFall = ~sclSync & st_q.scl;
    ev.start   = sclSync & st_q.scl & st_q.sda & ~sdaSync;
    ev.stop    = sclSync & st_q.scl & ~st_q.sda & sdaSync;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end
endmodule : tws_edge
`default_nettype wire

// >>> tws_top.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tws_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclPinIn,
  input  wire logic        sdaPinIn,
  output logic             sclPinOut,
  output logic             sclPinOe,
  output logic             sdaPinOut,
  output logic             sdaPinOe,
  output logic             irqReq
);

  typedef struct packed {
    logic [7:0]         ctrl;
    logic [7:0]         own;
    logic [7:0]         data;
    logic [2:0]         cfg;
    tws_pkg::tws_slv_e  slv;
    logic [3:0]         cnt;
    logic [7:0]         shift;
    logic               first;
    logic               nack;
    logic               acced;
    logic               halted;
    tws_pkg::tws_pins_s pins;
    logic               irq;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } tws_top_s;

  localparam tws_top_s ST_RST = '{
    ctrl: tws_pkg::CTRL_RST, own: tws_pkg::OWN_RST, data: tws_pkg::DATA_RST,
    cfg: tws_pkg::CFG_RST, slv: tws_pkg::SL_IDLE, cnt: 4'h0, shift: 8'h00,
    first: 1'b0, nack: 1'b0, acced: 1'b0, halted: 1'b0, pins: 4'h0,
    irq: 1'b0, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};

  tws_top_s          st_q;
  tws_top_s          st_d;
  tws_pkg::tws_bus_s ev;
  logic [1:0]        pinSync;
  tws_pkg::tws_rsel_e rsel;
  logic              acc;
  logic              dataAcc;
  logic              setEv;
  logic              slaveOn;
  logic              stretch;
  logic              txBit;

  // ----------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------
  tws_sync u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({sclPinIn, sdaPinIn}),
    .dout    (pinSync)
  );

  tws_edge u_edge (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .sclSync (pinSync[1]),
    .sdaSync (pinSync[0]),
    .ev      (ev)
  );

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  function automatic tws_pkg::tws_rsel_e decode(input logic [11:0] a);
    case (a)
      tws_pkg::CTRL_ADDR: decode = tws_pkg::RS_CTRL;
      tws_pkg::OWN_ADDR:  decode = tws_pkg::RS_OWN;
      tws_pkg::DATA_ADDR: decode = tws_pkg::RS_DATA;
      tws_pkg::CFG_ADDR:  decode = tws_pkg::RS_CFG;
      default:            decode = tws_pkg::RS_NONE;
    endcase
  endfunction : decode

  assign rsel    = decode(paddr);
  assign acc     = psel & penable & st_q.pready;
  assign dataAcc = acc & (rsel == tws_pkg::RS_DATA);
  assign slaveOn = ~st_q.ctrl[tws_pkg::CTRL_MSEL] & ~st_q.cfg[tws_pkg::CFG_SSEL]
                   & ~st_q.ctrl[tws_pkg::CTRL_IRST] & ~st_q.halted;
  assign stretch = st_q.ctrl[tws_pkg::CTRL_FLAG] & (st_q.slv != tws_pkg::SL_IDLE)
                   & ~ev.sclS;
  assign txBit   = (st_q.cnt == 4'h0) ? st_q.data[7] : st_q.shift[7];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d        = st_q;
    setEv       = 1'b0;
    st_d.pready = psel & ~penable;
    if (psel & ~penable) begin
      st_d.pslverr = (rsel == tws_pkg::RS_NONE);
      case (rsel)
        tws_pkg::RS_CTRL: st_d.prdata = {24'h00_0000, st_q.ctrl};
        tws_pkg::RS_OWN:  st_d.prdata = {24'h00_0000, st_q.own};
        tws_pkg::RS_DATA: st_d.prdata = {24'h00_0000, st_q.data};
        tws_pkg::RS_CFG:  st_d.prdata = {29'h0000_0000, st_q.cfg};
        default:          st_d.prdata = 32'h0000_0000;
      endcase
    end
    if (acc & pwrite) begin
      case (rsel)
        tws_pkg::RS_CTRL: st_d.ctrl[7:tws_pkg::CTRL_SW_LO] = pwdata[7:tws_pkg::CTRL_SW_LO];
        tws_pkg::RS_OWN:  st_d.own = pwdata[7:0];
        tws_pkg::RS_DATA: st_d.data = pwdata[7:0];
        tws_pkg::RS_CFG:  st_d.cfg = pwdata[2:0];
        default:          st_d.cfg = st_q.cfg;
      endcase
    end
    if (dataAcc) begin
      st_d.ctrl[tws_pkg::CTRL_FLAG] = 1'b0;
      st_d.acced = 1'b1;
      if (st_q.acced && st_q.slv != tws_pkg::SL_IDLE) begin
        st_d.halted = 1'b1;
      end
    end
    // Software master data input
    if (st_q.ctrl[tws_pkg::CTRL_MSEL] & ~st_q.ctrl[tws_pkg::CTRL_SDE] & ev.sclRise) begin
      st_d.ctrl[tws_pkg::CTRL_SDI] = ev.sdaS;
    end
    // Hardware slave sequencer
    if (st_q.ctrl[tws_pkg::CTRL_IRST]) begin
      st_d.slv    = tws_pkg::SL_IDLE;
      st_d.halted = 1'b0;
      st_d.acced  = 1'b0;
      st_d.ctrl[tws_pkg::CTRL_FLAG] = 1'b0;
    end else if (!slaveOn) begin
      st_d.slv = tws_pkg::SL_IDLE;
    end else if (ev.stop) begin
      st_d.slv = tws_pkg::SL_IDLE;
    end else if (ev.start) begin
      st_d.slv   = tws_pkg::SL_RX;
      st_d.cnt   = 4'h0;
      st_d.first = 1'b1;
    end else begin
      case (st_q.slv)
        tws_pkg::SL_RX: begin
          if (ev.sclRise && st_q.cnt != tws_pkg::BYTE_BITS) begin
            st_d.shift = {st_q.shift[6:0], ev.sdaS};
            st_d.cnt   = st_q.cnt + 4'h1;
          end
          if (ev.sclFall && st_q.cnt == tws_pkg::BYTE_BITS) begin
            if (!st_q.first || st_q.shift[7:1] == st_q.own[6:0]) begin
              st_d.data = st_q.shift;
              setEv     = 1'b1;
              st_d.slv  = tws_pkg::SL_ACKO;
              if (st_q.first) begin
                st_d.ctrl[tws_pkg::CTRL_DIR] = st_q.shift[0];
              end
            end else begin
              st_d.slv = tws_pkg::SL_IDLE;
            end
          end
        end
        tws_pkg::SL_ACKO: begin
          if (ev.sclFall) begin
            st_d.cnt   = 4'h0;
            st_d.first = 1'b0;
            st_d.slv   = st_q.ctrl[tws_pkg::CTRL_DIR] ? tws_pkg::SL_TX : tws_pkg::SL_RX;
          end
        end
        tws_pkg::SL_TX: begin
          if (ev.sclFall) begin
            st_d.shift = (st_q.cnt == 4'h0) ? {st_q.data[6:0], 1'b0}
                                             : {st_q.shift[6:0], 1'b0};
            st_d.cnt   = st_q.cnt + 4'h1;
            if (st_q.cnt == tws_pkg::TX_LAST) begin
              st_d.slv = tws_pkg::SL_ACKI;
            end
          end
        end
        tws_pkg::SL_ACKI: begin
          if (ev.sclRise) begin
            st_d.nack = ev.sdaS;
          end
          if (ev.sclFall) begin
            setEv    = 1'b1;
            st_d.cnt = 4'h0;
            st_d.slv = st_q.nack ? tws_pkg::SL_IDLE : tws_pkg::SL_TX;
          end
        end
        default: st_d.slv = tws_pkg::SL_IDLE;
      endcase
    end
    // Hardware set wins over a clearing access
    if (setEv) begin
      st_d.ctrl[tws_pkg::CTRL_FLAG] = 1'b1;
      st_d.acced = 1'b0;
    end
    // Pin drive
    if (st_q.cfg[tws_pkg::CFG_SSEL]) begin
      st_d.pins = 4'h0;
    end else if (st_q.ctrl[tws_pkg::CTRL_MSEL]) begin
      st_d.pins.sdaOut = st_q.ctrl[tws_pkg::CTRL_SDO];
      st_d.pins.sdaOe  = st_q.ctrl[tws_pkg::CTRL_SDE];
      st_d.pins.sclOut = st_q.ctrl[tws_pkg::CTRL_SCO];
      st_d.pins.sclOe  = 1'b1;
    end else begin
      st_d.pins.sdaOut = 1'b0;
      st_d.pins.sdaOe  = (st_q.slv == tws_pkg::SL_ACKO)
                         | ((st_q.slv == tws_pkg::SL_TX) & ~txBit);
      st_d.pins.sclOut = 1'b0;
      st_d.pins.sclOe  = stretch;
    end
    st_d.irq = st_d.ctrl[tws_pkg::CTRL_FLAG] & st_d.cfg[tws_pkg::CFG_IE]
               & st_d.cfg[tws_pkg::CFG_GIE];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata    = st_q.prdata;
  assign pready    = st_q.pready;
  assign pslverr   = st_q.pslverr;
  assign sclPinOut = st_q.pins.sclOut;
  assign sclPinOe  = st_q.pins.sclOe;
  assign sdaPinOut = st_q.pins.sdaOut;
  assign sdaPinOe  = st_q.pins.sdaOe;
  assign irqReq    = st_q.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic masterOn;
  assign masterOn = st_q.ctrl[tws_pkg::CTRL_MSEL] & ~st_q.cfg[tws_pkg::CFG_SSEL];

  property p_scl_master;
    masterOn |=> sclPinOe && sclPinOut == $past(st_q.ctrl[tws_pkg::CTRL_SCO]);
  endproperty
  a_scl_master: assert property (p_scl_master)
    else $error("clock pin not following clock output bit");

  property p_sda_drive;
    masterOn && st_q.ctrl[tws_pkg::CTRL_SDE]
      |=> sdaPinOe && sdaPinOut == $past(st_q.ctrl[tws_pkg::CTRL_SDO]);
  endproperty
  a_sda_drive: assert property (p_sda_drive)
    else $error("data pin not following data output bit");

  property p_sda_release;
    masterOn && !st_q.ctrl[tws_pkg::CTRL_SDE] |=> !sdaPinOe;
  endproperty
  a_sda_release: assert property (p_sda_release)
    else $error("data pin driven while drive disabled");

  property p_sdi_capture;
    st_q.ctrl[tws_pkg::CTRL_MSEL] && !st_q.ctrl[tws_pkg::CTRL_SDE] && ev.sclRise
      |=> st_q.ctrl[tws_pkg::CTRL_SDI] == $past(ev.sdaS);
  endproperty
  a_sdi_capture: assert property (p_sdi_capture)
    else $error("data input bit missed clock rise");

  property p_flag_clear;
    dataAcc && !setEv |=> !st_q.ctrl[tws_pkg::CTRL_FLAG] ##1 !irqReq;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("data access did not clear event flag");

  property p_irq_gate;
    irqReq == (st_q.ctrl[tws_pkg::CTRL_FLAG] && st_q.cfg[tws_pkg::CFG_IE]
               && st_q.cfg[tws_pkg::CFG_GIE]);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt not equal to flag and both enables");

  sequence s_stretch_hold;
    stretch && slaveOn ##1 sclPinOe && !sclPinOut;
  endsequence
  property p_stretch;
    stretch && slaveOn |-> s_stretch_hold;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock not held low while flag set");

  property p_iface_reset;
    st_q.ctrl[tws_pkg::CTRL_IRST] |=> st_q.slv == tws_pkg::SL_IDLE && !st_q.halted;
  endproperty
  a_iface_reset: assert property (p_iface_reset)
    else $error("interface reset did not idle slave");

  property p_double_access;
    dataAcc && st_q.acced && st_q.slv != tws_pkg::SL_IDLE
      && !st_q.ctrl[tws_pkg::CTRL_IRST] |=> st_q.halted;
  endproperty
  a_double_access: assert property (p_double_access)
    else $error("second data access did not halt slave");

  sequence s_stop_seen;
    ev.stop && slaveOn;
  endsequence
  property p_stop_idle;
    s_stop_seen |=> st_q.slv == tws_pkg::SL_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return slave to idle");

endmodule : tws_top
`default_nettype wire

// >>> tws_peer_master.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External two-wire master, open-drain
// ----------------------------------------
module tws_peer_master #(
  parameter int HALF = 10
) (
  input  wire logic clk_sys,
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output logic      sclLow,
  output logic      sdaLow
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic drvSda(input logic b);
    sdaLow <= !b;
  endtask : drvSda
  // Release clock, then wait out a stretch
  task automatic sclUp();
    sclLow <= 1'b0;
    do begin
      tick(1);
    end while (sclLine !== 1'b1);
  endtask : sclUp
  task automatic sendStart();
    sdaLow <= 1'b1;
    tick(HALF);
    sclLow <= 1'b1;
    tick(HALF / 2);
  endtask : sendStart
  task automatic sendStop();
    sdaLow <= 1'b1;
    tick(HALF / 2);
    sclUp();
    tick(HALF);
    sdaLow <= 1'b0;
    tick(HALF);
  endtask : sendStop
  // Data changes only a quarter period after the clock fell
  task automatic xferBit(input logic b, output logic s);
    sdaLow <= !b;
    tick(HALF / 2);
    sclUp();
    s = sdaLine;
    tick(HALF - 1);
    sclLow <= 1'b1;
    tick(HALF / 2);
  endtask : xferBit
  task automatic byteXfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      xferBit(d[i], q[i]);
    end
  endtask : byteXfer
endmodule : tws_peer_master
`default_nettype wire

// >>> tws_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tws_top_tb;
  logic        clk_sys;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclPinOut;
  logic        sclPinOe;
  logic        sdaPinOut;
  logic        sdaPinOe;
  logic        irqReq;
  logic        peerSclLow;
  logic        peerSdaLow;
  wire logic   sclLine;
  wire logic   sdaLine;
  logic [31:0] rv;
  logic        lastErr;
  logic [7:0]  d;
  logic [7:0]  q;
  logic [6:0]  own7;
  logic        a;
  logic        b;
  int          seed;
  int          err_total;
  int          comparisons;
  int          cycles;

  assign sclLine = (sclPinOe ? sclPinOut : 1'b1) & ~peerSclLow;
  assign sdaLine = (sdaPinOe ? sdaPinOut : 1'b1) & ~peerSdaLow;

  tws_top DUT (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .sclPinIn (sclLine),
    .sdaPinIn (sdaLine),
    .sclPinOut(sclPinOut),
    .sclPinOe (sclPinOe),
    .sdaPinOut(sdaPinOut),
    .sdaPinOe (sdaPinOe),
    .irqReq   (irqReq)
  );

  tws_peer_master #(.HALF(10)) peer (
    .clk_sys(clk_sys),
    .sclLine(sclLine),
    .sdaLine(sdaLine),
    .sclLow (peerSclLow),
    .sdaLow (peerSdaLow)
  );

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rv = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic waitFlag();
    do begin
      apb(1'b0, tws_pkg::CTRL_ADDR, 32'h0);
    end while (rv[0] !== 1'b1);
  endtask : waitFlag

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h632D;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk("pinsAtReset", {sclPinOe, sdaPinOe, irqReq}, 3'b000);
    apb(1'b0, tws_pkg::CTRL_ADDR, 32'h0);
    chk("ctrlReset", rv, 32'h0);
    apb(1'b0, tws_pkg::OWN_ADDR, 32'h0);
    chk("ownReset", rv, 32'h55);
    apb(1'b0, tws_pkg::DATA_ADDR, 32'h0);
    chk("dataReset", rv, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("unmappedRead", rv, 32'h0);
    chk("unmappedErr", lastErr, 1'b1);
    own7 = 7'($random(seed));
    apb(1'b1, tws_pkg::OWN_ADDR, {25'h0, own7});
    apb(1'b0, tws_pkg::OWN_ADDR, 32'h0);
    chk("ownWrite", rv, {25'h0, own7});
    // Software master: every combination of the pin bits
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, tws_pkg::CTRL_ADDR, {24'h0, 3'(i), 5'h08});
      tick(3);
      chk("sclOe", sclPinOe, 1'b1);
      chk("sclOut", sclPinOut, i[0]);
      chk("sdaOe", sdaPinOe, i[1]);
      if (i[1]) chk("sdaOut", sdaPinOut, i[2]);
    end
    for (int i = 0; i < 6; i++) begin
      b = 1'($random(seed));
      peer.drvSda(b);
      apb(1'b1, tws_pkg::CTRL_ADDR, 32'h08);
      apb(1'b1, tws_pkg::CTRL_ADDR, 32'h28);
      tick(8);
      peer.drvSda(~b);
      tick(8);
      apb(1'b0, tws_pkg::CTRL_ADDR, 32'h0);
      chk("sdaIn", rv[4], b);
    end
    apb(1'b1, tws_pkg::CTRL_ADDR, 32'h0);
    peer.drvSda(1'b1);
    tick(8);
    // Slave receive, then a second data access halts it
    apb(1'b1, tws_pkg::CFG_ADDR, 32'h3);
    peer.sendStart();
    peer.byteXfer({own7, 1'b0}, q);
    waitFlag();
    chk("irqSet", irqReq, 1'b1);
    chk("stretch", {sclPinOe, sclPinOut}, 2'b10);
    chk("dirRx", rv[1], 1'b0);
    apb(1'b0, tws_pkg::DATA_ADDR, 32'h0);
    chk("addrByte", rv, {24'h0, own7, 1'b0});
    tick(4);
    chk("irqClear", irqReq, 1'b0);
    apb(1'b0, tws_pkg::CTRL_ADDR, 32'h0);
    chk("flagClear", rv[0], 1'b0);
    peer.xferBit(1'b1, a);
    chk("addrAck", a, 1'b0);
    d = 8'($random(seed));
    peer.byteXfer(d, q);
    waitFlag();
    apb(1'b0, tws_pkg::DATA_ADDR, 32'h0);
    chk("rxByte", rv, {24'h0, d});
    apb(1'b0, tws_pkg::DATA_ADDR, 32'h0);
    peer.xferBit(1'b1, a);
    chk("haltNoAck", a, 1'b1);
    chk("haltRelease", sclPinOe, 1'b0);
    peer.sendStop();
    apb(1'b1, tws_pkg::CTRL_ADDR, 32'h04);
    apb(1'b1, tws_pkg::CTRL_ADDR, 32'h00);
    apb(1'b0, tws_pkg::CTRL_ADDR, 32'h0);
    chk("ifaceReset", rv, 32'h0);
    // Slave transmit with the interrupt masked, ended by a NACK
    apb(1'b1, tws_pkg::CFG_ADDR, 32'h1);
    peer.sendStart();
    peer.byteXfer({own7, 1'b1}, q);
    waitFlag();
    chk("irqMasked", irqReq, 1'b0);
    chk("dirTx", rv[1], 1'b1);
    d = 8'($random(seed));
    apb(1'b1, tws_pkg::DATA_ADDR, {24'h0, d});
    peer.xferBit(1'b1, a);
    chk("readAck", a, 1'b0);
    peer.byteXfer(8'hFF, q);
    chk("txByte", q, d);
    peer.xferBit(1'b1, a);
    waitFlag();
    chk("nackFlag", rv[0], 1'b1);
    tick(4);
    chk("nackIdle", {sclPinOe, sdaPinOe}, 2'b00);
    peer.sendStop();
    apb(1'b0, tws_pkg::DATA_ADDR, 32'h0);
    // Foreign address, then shift port selected: no answer
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, tws_pkg::CFG_ADDR, i ? 32'h4 : 32'h3);
      peer.sendStart();
      peer.byteXfer({i ? own7 : own7 ^ 7'h01, 1'b0}, q);
      peer.xferBit(1'b1, a);
      chk("noAck", a, 1'b1);
      apb(1'b0, tws_pkg::CTRL_ADDR, 32'h0);
      chk("noFlag", rv[0], 1'b0);
      peer.sendStop();
    end
    report_and_stop();
  end
endmodule : tws_top_tb
`default_nettype wire
